/* File: rtl/lcc_cfg.svh */
// Constants of the configurable logic cells: offsets, fields, modes, timing.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef LCC_CFG_SVH
`define LCC_CFG_SVH

// Cell count and bus widths
`define LCC_NUM_CELLS   4
`define LCC_ADDR_W      12
`define LCC_SEL_W       5

// Function selections
`define LCC_MODE_OFF    8'h00
`define LCC_MODE_AND    8'h01
`define LCC_MODE_OR     8'h02
`define LCC_MODE_XOR    8'h03
`define LCC_MODE_LATCH  8'h0A
`define LCC_MODE_TOGGLE 8'h14
`define LCC_MODE_DFF    8'h1E

// Register offsets (cell config words sit at 4 * cell index)
`define LCC_CFG_OFS     12'h000
`define LCC_STAT_OFS    12'h010
`define LCC_PASS_OFS    12'h014

// Config word fields and reset value
`define LCC_MODE_LSB    0
`define LCC_IN1_LSB     8
`define LCC_IN2_LSB     16
`define LCC_CFG_MASK    32'h001F1FFF
`define LCC_CFG_RST     32'h00000000
`define LCC_BUSY_BIT    8

// Source select map
`define LCC_SRC_ONE     1
`define LCC_SRC_CELL    2
`define LCC_SRC_DIN     8
`define LCC_SRC_STAT    16

// Bus answers
`define LCC_RESP_OKAY   2'h0
`define LCC_RESP_SLVERR 2'h2

// Processing period
`define LCC_TICK_MS     16
`define LCC_CLK_KHZ     125000
`define LCC_TICK_CYCLES (`LCC_TICK_MS * `LCC_CLK_KHZ)

`endif

/* File: rtl/lcc_pkg.sv */
// Types shared by the configurable logic cells.
// Assumes the constants header supplies the widths.
`include "lcc_cfg.svh"

package lcc_pkg;
    typedef logic [7:0]            lcc_mode_t;
    typedef logic [`LCC_SEL_W-1:0] lcc_sel_t;
    typedef enum {
        st_idle,
        st_eval
    } lcc_state_t;
endpackage

/* File: rtl/lcc_cell.sv */
// One logic cell: gate, set/clear latch, toggle or D flip-flop.
// Assumes eval_i pulses once per pass, inputs settled in that cycle.
`timescale 1ns/100ps
`include "lcc_cfg.svh"

module lcc_cell (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    // Evaluation strobe and function
    input  wire logic              eval_i,
    input  wire lcc_pkg::lcc_mode_t mode_i,
    // Selected inputs
    input  wire logic              first_cell_input_i,
    input  wire logic              second_cell_input_i,
    // Result
    output logic                   q_o
);

    logic q_reg;
    logic q_next;
    logic prev1_reg;
    logic prev1_next;
    logic prev2_reg;
    logic prev2_next;
    logic rise1;
    logic rise2;

    // Edges compare this pass against the level kept from the last one
    assign rise1 = first_cell_input_i & ~prev1_reg;   // see RULE16
    assign rise2 = second_cell_input_i & ~prev2_reg;  // see RULE16

    // Next output, only changes on the evaluation strobe
    always_comb
    begin
        q_next     = q_reg;
        prev1_next = prev1_reg;
        prev2_next = prev2_reg;
        if (eval_i)
        begin
            prev1_next = first_cell_input_i;
            prev2_next = second_cell_input_i;
            case (mode_i)
                `LCC_MODE_AND:    q_next = first_cell_input_i & second_cell_input_i; // see RULE7
                `LCC_MODE_OR:     q_next = first_cell_input_i | second_cell_input_i; // see RULE8
                `LCC_MODE_XOR:    q_next = first_cell_input_i ^ second_cell_input_i; // see RULE9
                `LCC_MODE_LATCH:
                begin
                    // Clear dominates set
                    if (second_cell_input_i)
                        q_next = 1'b0;                // see RULE11
                    else if (first_cell_input_i)
                        q_next = 1'b1;                // see RULE10
                end
                `LCC_MODE_TOGGLE:
                begin
                    // Second input is deliberately unused here
                    if (rise1)
                        q_next = ~q_reg;              // see RULE12 RULE13
                end
                `LCC_MODE_DFF:
                begin
                    if (rise2)
                        q_next = first_cell_input_i;  // see RULE14 RULE15
                end
                // Off and unknown selections force the output low
                default:          q_next = 1'b0;      // see RULE6
            endcase
        end
    end

    // State registers, all cleared on reset
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q_reg     <= 1'b0;                        // see RULE17
            prev1_reg <= 1'b0;
            prev2_reg <= 1'b0;
        end
        else
        begin
            q_reg     <= q_next;
            prev1_reg <= prev1_next;
            prev2_reg <= prev2_next;
        end
    end

    assign q_o = q_reg;

    property p_off_zero;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        eval_i && mode_i == `LCC_MODE_OFF |=> !q_o;
    endproperty
    a_off_zero: assert property (p_off_zero) // see RULE6
        else $error("Off cell output not low");

    property p_and;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        eval_i && mode_i == `LCC_MODE_AND
        |=> q_o == ($past(first_cell_input_i) && $past(second_cell_input_i));
    endproperty
    a_and: assert property (p_and) // see RULE7
        else $error("AND cell output wrong");

    property p_or;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        eval_i && mode_i == `LCC_MODE_OR
        |=> q_o == ($past(first_cell_input_i) || $past(second_cell_input_i));
    endproperty
    a_or: assert property (p_or) // see RULE8
        else $error("OR cell output wrong");

    property p_xor;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        eval_i && mode_i == `LCC_MODE_XOR
        |=> q_o == ($past(first_cell_input_i) != $past(second_cell_input_i));
    endproperty
    a_xor: assert property (p_xor) // see RULE9
        else $error("XOR cell output wrong");

    property p_latch;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        eval_i && mode_i == `LCC_MODE_LATCH && !first_cell_input_i
        && !second_cell_input_i |=> $stable(q_o);
    endproperty
    a_latch: assert property (p_latch) // see RULE10
        else $error("Latch did not hold");

    property p_latch_clear;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        eval_i && mode_i == `LCC_MODE_LATCH && second_cell_input_i |=> !q_o;
    endproperty
    a_latch_clear: assert property (p_latch_clear) // see RULE11
        else $error("Latch clear lost to set");

    property p_toggle;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        eval_i && mode_i == `LCC_MODE_TOGGLE
        |=> q_o == ($past(rise1) ? !$past(q_o) : $past(q_o));
    endproperty
    a_toggle: assert property (p_toggle) // see RULE12
        else $error("Toggle output wrong");

    property p_dff;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        eval_i && mode_i == `LCC_MODE_DFF
        |=> q_o == ($past(rise2) ? $past(first_cell_input_i) : $past(q_o));
    endproperty
    a_dff: assert property (p_dff) // see RULE14
        else $error("D flip-flop output wrong");

    property p_idle_hold;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !eval_i |=> $stable(q_o) && $stable(prev1_reg);
    endproperty
    a_idle_hold: assert property (p_idle_hold) // see RULE5
        else $error("Cell changed outside its pass slot");

endmodule

/* File: rtl/lcc_top.sv */
// Four configurable logic cells evaluated in order once per period.
// Assumes an AXI4-Lite master on ref_clk_i and asynchronous digital inputs.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "lcc_cfg.svh"

// Overview of operation
// RULE1: Four cells, each configured on its own.
// RULE2: Two inputs, one output, usable elsewhere.
// RULE3: Inputs select pins, status or cells.
// RULE4: Cells evaluated in ascending index order.
// RULE5: All cells re-evaluated every 16 ms.
// RULE6: Selection 0 forces output low.
// RULE7: Selection 1 gives AND.
// RULE8: Selection 2 gives OR.
// RULE9: Selection 3 gives XOR.
// RULE10: Selection 10: set, clear, or hold latch.
// RULE11: Latch with both inputs high clears.
// RULE12: Selection 20 toggles on input one rise.
// RULE13: Toggle mode ignores input two.
// RULE14: Selection 30 loads input one on rise.
// RULE15: D mode holds except on rising edge.
// RULE16: Edges compare against previous pass level.
// RULE17: Reset clears outputs, states, previous levels.
module lcc_top #(
    parameter int unsigned NUM_DIN     = 8,
    parameter int unsigned NUM_STAT    = 8,
    parameter int unsigned TICK_CYCLES = `LCC_TICK_CYCLES
)(
    // Clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_b_i,
    // AXI4-Lite write address
    input  wire logic [`LCC_ADDR_W-1:0]  s_axi_awaddr_i,
    input  wire logic                    s_axi_awvalid_i,
    output logic                         s_axi_awready_o,
    // AXI4-Lite write data
    input  wire logic [31:0]             s_axi_wdata_i,
    input  wire logic [3:0]              s_axi_wstrb_i,
    input  wire logic                    s_axi_wvalid_i,
    output logic                         s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0]                   s_axi_bresp_o,
    output logic                         s_axi_bvalid_o,
    input  wire logic                    s_axi_bready_i,
    // AXI4-Lite read address
    input  wire logic [`LCC_ADDR_W-1:0]  s_axi_araddr_i,
    input  wire logic                    s_axi_arvalid_i,
    output logic                         s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0]                  s_axi_rdata_o,
    output logic [1:0]                   s_axi_rresp_o,
    output logic                         s_axi_rvalid_o,
    input  wire logic                    s_axi_rready_i,
    // Signal sources
    input  wire logic [NUM_DIN-1:0]      din_i,
    input  wire logic [NUM_STAT-1:0]     stat_i,
    // Cell results
    output logic [`LCC_NUM_CELLS-1:0]    cell_out_o,
    output logic                         pass_done_o
);

    localparam int unsigned N = `LCC_NUM_CELLS;

    logic [31:0]          cfg_reg [N];
    logic [31:0]          cfg_next [N];
    logic [NUM_DIN-1:0]   din_meta_reg;
    logic [NUM_DIN-1:0]   din_sync_reg;
    logic [31:0]          tick_cnt_reg;
    logic [31:0]          tick_cnt_next;
    logic                 tick;
    lcc_pkg::lcc_state_t  state_reg;
    lcc_pkg::lcc_state_t  state_next;
    logic [1:0]           idx_reg;
    logic [1:0]           idx_next;
    logic                 pass_reg;
    logic                 pass_next;
    logic [31:0]          pcnt_reg;
    logic [31:0]          pcnt_next;
    logic [N-1:0]         eval_vec;
    logic [N-1:0]         cell_q;
    logic [31:0]          src_vec;
    logic                 awready_reg;
    logic                 awready_next;
    logic                 wready_reg;
    logic                 wready_next;
    logic                 bvalid_reg;
    logic                 bvalid_next;
    logic [1:0]           bresp_reg;
    logic [1:0]           bresp_next;
    logic                 arready_reg;
    logic                 arready_next;
    logic                 rvalid_reg;
    logic                 rvalid_next;
    logic [1:0]           rresp_reg;
    logic [1:0]           rresp_next;
    logic [31:0]          rdata_reg;
    logic [31:0]          rdata_next;
    logic                 wr_take;
    logic                 rd_take;

    // Pins are asynchronous, so two flops before any cell sees them
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            din_meta_reg <= '0;
            din_sync_reg <= '0;
        end
        else
        begin
            din_meta_reg <= din_i;
            din_sync_reg <= din_meta_reg;
        end
    end

    // Source map shared by every cell input selector
    always_comb
    begin
        src_vec                             = 32'h00000000;
        src_vec[`LCC_SRC_ONE]               = 1'b1;
        src_vec[`LCC_SRC_CELL +: N]         = cell_q;         // see RULE3
        src_vec[`LCC_SRC_DIN +: NUM_DIN]    = din_sync_reg;   // see RULE3
        src_vec[`LCC_SRC_STAT +: NUM_STAT]  = stat_i;         // see RULE3
    end

    // Period counter; the pass starts when it wraps
    assign tick = (tick_cnt_reg == 32'h00000000);

    // Pass sequencer: one cell per cycle, lowest index first
    always_comb
    begin
        tick_cnt_next = tick ? 32'(TICK_CYCLES - 1) : tick_cnt_reg - 32'h00000001; // see RULE5
        state_next    = state_reg;
        idx_next      = idx_reg;
        pass_next     = 1'b0;
        pcnt_next     = pcnt_reg;
        case (state_reg)
            lcc_pkg::st_idle:
            begin
                if (tick)
                begin
                    state_next = lcc_pkg::st_eval;                 // see RULE5
                    idx_next   = 2'h0;
                end
            end
            lcc_pkg::st_eval:
            begin
                if (idx_reg == 2'(N - 1))
                begin
                    state_next = lcc_pkg::st_idle;
                    pass_next  = 1'b1;
                    pcnt_next  = pcnt_reg + 32'h00000001;
                end
                else
                    idx_next = idx_reg + 2'h1;                     // see RULE4
            end
            default:
                state_next = lcc_pkg::st_idle;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tick_cnt_reg <= 32'h00000000;
            state_reg    <= lcc_pkg::st_idle;
            idx_reg      <= 2'h0;
            pass_reg     <= 1'b0;
            pcnt_reg     <= 32'h00000000;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_next;
            state_reg    <= state_next;
            idx_reg      <= idx_next;
            pass_reg     <= pass_next;
            pcnt_reg     <= pcnt_next;
        end
    end

    // Strobe for the cell whose slot this is; later cells see updated lower ones
    always_comb
    begin
        for (int i = 0; i < N; i++)
            eval_vec[i] = (state_reg == lcc_pkg::st_eval) && (idx_reg == 2'(i)); // see RULE4
    end

    // Cells, each steered only by its own config word
    for (genvar g = 0; g < N; g++)
    begin : g_cell
        lcc_cell u_cell (
            .ref_clk_i           (ref_clk_i),
            .rst_b_i             (rst_b_i),
            .eval_i              (eval_vec[g]),
            .mode_i              (cfg_reg[g][`LCC_MODE_LSB +: 8]),                // see RULE1
            .first_cell_input_i  (src_vec[cfg_reg[g][`LCC_IN1_LSB +: `LCC_SEL_W]]), // see RULE3
            .second_cell_input_i (src_vec[cfg_reg[g][`LCC_IN2_LSB +: `LCC_SEL_W]]), // see RULE2
            .q_o                 (cell_q[g])
        );
    end

    // Write channel: both address and data must be offered before acceptance
    assign wr_take = s_axi_awvalid_i && awready_reg && s_axi_wvalid_i && wready_reg;

    always_comb
    begin
        awready_next = 1'b0;
        wready_next  = 1'b0;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        for (int i = 0; i < N; i++)
            cfg_next[i] = cfg_reg[i];
        if (bvalid_reg && s_axi_bready_i)
            bvalid_next = 1'b0;
        if (wr_take)
        begin
            bvalid_next = 1'b1;
            bresp_next  = `LCC_RESP_OKAY;
            if (s_axi_awaddr_i[`LCC_ADDR_W-1:4] == `LCC_CFG_OFS >> 4)
            begin
                for (int b = 0; b < 4; b++)
                    if (s_axi_wstrb_i[b])
                        cfg_next[s_axi_awaddr_i[3:2]][8*b +: 8] = s_axi_wdata_i[8*b +: 8];
                cfg_next[s_axi_awaddr_i[3:2]] = cfg_next[s_axi_awaddr_i[3:2]] & `LCC_CFG_MASK;
            end
            else if (s_axi_awaddr_i[`LCC_ADDR_W-1:2] == `LCC_STAT_OFS >> 2)
                bresp_next = `LCC_RESP_OKAY;          // Read-only, write dropped
            else if (s_axi_awaddr_i[`LCC_ADDR_W-1:2] == `LCC_PASS_OFS >> 2)
                bresp_next = `LCC_RESP_OKAY;          // Read-only, write dropped
            else
                bresp_next = `LCC_RESP_SLVERR;
        end
        else if (s_axi_awvalid_i && s_axi_wvalid_i && !awready_reg && !bvalid_reg)
        begin
            awready_next = 1'b1;
            wready_next  = 1'b1;
        end
    end

    // Read channel: one outstanding read, data registered with the answer
    assign rd_take = s_axi_arvalid_i && arready_reg;

    always_comb
    begin
        arready_next = 1'b0;
        rvalid_next  = rvalid_reg;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        if (rvalid_reg && s_axi_rready_i)
            rvalid_next = 1'b0;
        if (rd_take)
        begin
            rvalid_next = 1'b1;
            rresp_next  = `LCC_RESP_OKAY;
            if (s_axi_araddr_i[`LCC_ADDR_W-1:4] == `LCC_CFG_OFS >> 4)
                rdata_next = cfg_reg[s_axi_araddr_i[3:2]];
            else if (s_axi_araddr_i[`LCC_ADDR_W-1:2] == `LCC_STAT_OFS >> 2)
            begin
                rdata_next                = 32'h00000000;
                rdata_next[N-1:0]         = cell_q;                 // see RULE2
                rdata_next[`LCC_BUSY_BIT] = (state_reg == lcc_pkg::st_eval);
            end
            else if (s_axi_araddr_i[`LCC_ADDR_W-1:2] == `LCC_PASS_OFS >> 2)
                rdata_next = pcnt_reg;
            else
            begin
                rdata_next = 32'h00000000;
                rresp_next = `LCC_RESP_SLVERR;
            end
        end
        else if (s_axi_arvalid_i && !arready_reg && !rvalid_reg)
            arready_next = 1'b1;
    end

    // Bus and config registers
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < N; i++)
                cfg_reg[i] <= `LCC_CFG_RST;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= 2'h0;
            rdata_reg   <= 32'h00000000;
        end
        else
        begin
            for (int i = 0; i < N; i++)
                cfg_reg[i] <= cfg_next[i];
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o  = wready_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rresp_o   = rresp_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign cell_out_o      = cell_q;
    assign pass_done_o     = pass_reg;

    property p_order;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        state_reg == lcc_pkg::st_eval && idx_reg != 2'(N - 1)
        |=> state_reg == lcc_pkg::st_eval && idx_reg == $past(idx_reg) + 2'h1;
    endproperty
    a_order: assert property (p_order) // see RULE4
        else $error("Cells not evaluated in ascending order");

    property p_pass_walk;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        state_reg == lcc_pkg::st_idle && tick
        |=> eval_vec == 4'h1 ##1 eval_vec == 4'h2 ##1 eval_vec == 4'h4
        ##1 eval_vec == 4'h8 ##1 pass_done_o && eval_vec == 4'h0;
    endproperty
    a_pass_walk: assert property (p_pass_walk) // see RULE4
        else $error("Pass did not visit cells one to four");

    property p_period;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        tick |=> tick_cnt_reg == 32'(TICK_CYCLES - 1);
    endproperty
    a_period: assert property (p_period) // see RULE5
        else $error("Period counter reload wrong");

    property p_one_slot;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $onehot0(eval_vec) && (state_reg == lcc_pkg::st_idle) == (eval_vec == 4'h0);
    endproperty
    a_one_slot: assert property (p_one_slot) // see RULE4
        else $error("More than one cell evaluated at once");

    property p_cfg_own;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        wr_take && s_axi_awaddr_i[`LCC_ADDR_W-1:4] == 8'h00
        && s_axi_awaddr_i[3:2] != 2'h1 |=> $stable(cfg_reg[1]);
    endproperty
    a_cfg_own: assert property (p_cfg_own) // see RULE1
        else $error("Write to one cell altered another");

endmodule

/* File: verif/lcc_sig_src.sv */
// Far-side model: digital input terminals and internal status lines.
// Assumes the bench hands it new levels well away from any pass.
`timescale 1ns/100ps

module lcc_sig_src (
    // Clock
    input  wire logic       ref_clk_i,
    // New levels from the bench
    input  wire logic       upd_i,
    input  wire logic [7:0] din_next_i,
    input  wire logic [7:0] stat_next_i,
    // Levels seen by the cells
    output logic      [7:0] din_o,
    output logic      [7:0] stat_o
);
    // Levels move only on request, so a pass never sees a half-changed set
    always_ff @(posedge ref_clk_i)
    begin
        if (upd_i)
        begin
            din_o  <= din_next_i;
            stat_o <= stat_next_i;
        end
    end
endmodule

/* File: verif/test_configurable_logic_cells.sv */
// Self-checking bench: cell results compared with a pass-level model.
// Assumes the design files and the signal source model compile first.
`timescale 1ns/100ps
`include "lcc_cfg.svh"

module test_configurable_logic_cells;
    logic        ref_clk_i, rst_b_i, upd, pass_done;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  din, stat, din_nx, stat_nx;
    logic [3:0]  cell_out;
    int          err_total, comparisons, seed, gap, passes;
    int          q[4], p1[4], p2[4], mode[4];
    int          sel1[4] = '{16, 2, 18, 8};
    int          sel2[4] = '{5, 17, 3, 19};
    int          modes[8] = '{0, 1, 2, 3, 10, 20, 30, 7};

    lcc_top #(.TICK_CYCLES(40)) lcc_top_inst (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .din_i(din), .stat_i(stat), .cell_out_o(cell_out),
        .pass_done_o(pass_done));
    lcc_sig_src lcc_sig_src_inst (.ref_clk_i(ref_clk_i), .upd_i(upd),
        .din_next_i(din_nx), .stat_next_i(stat_nx), .din_o(din), .stat_o(stat));

    // Clock, 8 ns period
    initial
    begin
        ref_clk_i = 1'h0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic axw(logic [11:0] a, logic [31:0] dv, logic [1:0] er);
        bit aw, w;
        @(posedge ref_clk_i);
        {awaddr, wdata} <= {a, dv};
        {awvalid, wvalid, bready} <= 3'h7;
        while (!(aw && w))
        begin
            @(posedge ref_clk_i);
            aw |= awready;
            w |= wready;
            awvalid <= !aw;
            wvalid <= !w;
        end
        do @(posedge ref_clk_i); while (!bvalid);
        chk("bresp", bresp, er);
        bready <= 1'h0;
    endtask

    task automatic axr(logic [11:0] a);
        @(posedge ref_clk_i);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge ref_clk_i); while (!arready);
        arvalid <= 1'h0;
        do @(posedge ref_clk_i); while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'h0;
    endtask

    function automatic int src(int s);
        if (s == 1) return 1;
        if (s >= 2 && s <= 5) return q[s-2];
        if (s >= 8 && s <= 15) return din_nx[s-8];
        if (s >= 16 && s <= 23) return stat_nx[s-16];
        return 0;
    endfunction

    // Cells in index order, so a later cell sees this pass's earlier results
    task automatic next_pass();
        int a, b;
        do @(posedge ref_clk_i); while (!pass_done);
        for (int c = 0; c < 4; c++)
        begin
            a = src(sel1[c]);
            b = src(sel2[c]);
            case (mode[c])
                1: q[c] = a & b;
                2: q[c] = a | b;
                3: q[c] = a ^ b;
                10: q[c] = b ? 0 : (a ? 1 : q[c]);
                20: q[c] = (a && !p1[c]) ? !q[c] : q[c];
                30: q[c] = (b && !p2[c]) ? a : q[c];
                default: q[c] = 0;
            endcase
            p1[c] = a;
            p2[c] = b;
        end
        chk("cell_out", cell_out, {q[3][0], q[2][0], q[1][0], q[0][0]});
    endtask

    // Spacing of completed passes, restarted by reset
    always @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            {gap, passes} <= 64'h0;
        else if (pass_done)
        begin
            if (gap > 0) chk("period", gap, 40);
            gap <= 1;
            passes <= passes + 1;
        end
        else if (gap > 0)
            gap <= gap + 1;
    end

    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        err_total++;
        report_and_stop();
    end

    // Main sequence: every mode, random inputs, then registers and reset
    initial
    begin
        seed = 93;
        {awaddr, araddr, wdata, din_nx, stat_nx} = '0;
        {awvalid, wvalid, bready, arvalid, rready, upd, rst_b_i} = '0;
        repeat (20) @(posedge ref_clk_i);
        rst_b_i <= 1'h1;
        do @(posedge ref_clk_i); while (!pass_done);
        chk("cell_out_rst", cell_out, 4'h0);
        foreach (modes[m])
        begin
            for (int c = 0; c < 4; c++)
            begin
                mode[c] = modes[m];
                axw(12'(4 * c), {11'h0, sel2[c][4:0], 3'h0, sel1[c][4:0], 8'(modes[m])},
                    `LCC_RESP_OKAY);
            end
            repeat (6)
            begin
                @(posedge ref_clk_i);
                stat_nx <= 8'($random(seed));
                din_nx <= 8'($random(seed));
                upd <= 1'h1;
                @(posedge ref_clk_i);
                upd <= 1'h0;
                next_pass();
            end
            $display("Mode %0d test done", modes[m]);
        end
        axr(`LCC_STAT_OFS);
        chk("status", d, {23'h0, 1'h0, 4'h0, q[3][0], q[2][0], q[1][0], q[0][0]});
        axr(`LCC_PASS_OFS);
        chk("pass_count", d, passes);
        axr(12'h018);
        chk("rresp_unmapped", r, `LCC_RESP_SLVERR);
        chk("rdata_unmapped", d, 32'h0);
        axw(12'h018, 32'h0, `LCC_RESP_SLVERR);
        axw(12'h00C, 32'hFFFFFFFF, `LCC_RESP_OKAY);
        axr(12'h00C);
        chk("cfg_mask", d, `LCC_CFG_MASK);
        $display("Register test done");
        @(posedge ref_clk_i);
        rst_b_i <= 1'h0;
        repeat (3) @(posedge ref_clk_i);
        chk("cell_out_mid_rst", cell_out, 4'h0);
        rst_b_i <= 1'h1;
        axr(12'h00C);
        chk("cfg_after_rst", d, `LCC_CFG_RST);
        $display("Reset test done");
        report_and_stop();
    end
endmodule
